// File: rtl/cqr_pkg.sv
package cqr_pkg;

	// =========================================================
	// Sweep modes
	typedef enum logic [1:0] {
		CQR_MODE_NORMAL  = 2'h0,
		CQR_MODE_ROLL    = 2'h1,
		CQR_MODE_XY      = 2'h2,
		CQR_MODE_DELAYED = 2'h3
	} cqr_mode_t;

	// =========================================================
	// Trace encodings
	typedef enum logic [1:0] {
		CQR_ENC_BYTE  = 2'h0,
		CQR_ENC_WORD  = 2'h1,
		CQR_ENC_ASCII = 2'h2
	} cqr_enc_t;

	// =========================================================
	// Decoded commands, handed in one at a time by the parser
	typedef enum logic [2:0] {
		CQR_CMD_NONE    = 3'h0,
		CQR_CMD_SETUP   = 3'h1,
		CQR_CMD_CAPTURE = 3'h2,
		CQR_CMD_QUERY   = 3'h3,
		CQR_CMD_TRACEQ  = 3'h4,
		CQR_CMD_PRESET  = 3'h5
	} cqr_cmd_t;

	// =========================================================
	// Characters, error codes and sizes
	localparam logic [7:0] CQR_CH_HASH  = 8'h23;
	localparam logic [7:0] CQR_CH_SEMI  = 8'h3b;
	localparam logic [7:0] CQR_CH_ZERO  = 8'h30;
	localparam logic [7:0] CQR_CH_COMMA = 8'h2c;
	localparam logic [7:0] CQR_CH_NL    = 8'h0a;
	localparam logic [7:0] CQR_ERR_CONFLICT    = 8'h01;
	localparam logic [7:0] CQR_ERR_INTERRUPTED = 8'h02;
	localparam int         CQR_CNT_DIGITS      = 5;
	localparam int         CQR_FIFO_DEPTH      = 8;

endpackage

// File: rtl/cqr_fifo.sv
`timescale 1ns/1ps

// =========================================================
// Output queue buffer
module cqr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             flush,
	// Write side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// Read side
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} cqr_fifo_st_t;

	cqr_fifo_st_t       s_q, s_d;
	logic [WIDTH-1:0]   mem [DEPTH];
	logic               wr, rd;

	assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = mem[s_q.rp];
	assign wr        = in_valid && in_ready;
	assign rd        = out_valid && out_ready;

	// Pointer and fill update; flush empties the queue at once
	always_comb begin
		s_d = s_q;
		if (wr) begin
			s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
		end
		if (rd) begin
			s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
		if (flush) begin
			s_d = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Storage has no reset; only written words are ever read
	always_ff @(posedge core_clk) begin
		if (wr) begin
			mem[s_q.wp] <= in_data;
		end
	end

	a_fifo_no_overflow: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// File: rtl/cqr_engine.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Capture done stops acquisition; record stays frozen for transfers.
// - Any setup change clears the stored trace buffer; here setup, preset, sweep mode writes and capture start pulse buf_clear.
// - Capture and trace queries run only in normal sweep; else conflict error.
// - Preset command returns sweep mode to normal.
// - Acquisition settings give point count, type and averaging count.
// - Averaging capture runs until at least the set number of sweeps.
// - Trace output starts only when addressed to talk.
// - Each point is sent as byte, word or ASCII per encoding.
// - Points go out in display order, leftmost first.
// - Device clear during capture aborts the capture.
// - Query answer waits in output queue until read or next command.
// - New command with unread answer flushes it and logs an error.
// - No answer is sent when no query is pending.
// - Block answer: hash, length digit, decimal count, then data bytes.
// - Several answers in one message are joined by semicolons; here a semicolon is sent only before a trace block that follows a short answer.
// - Commands execute only after linefeed or end-of-message arrives; here setup and preset act at once.
// - Device clear empties buffers, resets parser, drops pending commands.
module cqr_engine #(
	parameter int PTS_W = 10,
	parameter int AVG_W = 8
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Parsed command stream
	input  wire logic             cmd_valid,
	input  wire cqr_pkg::cqr_cmd_t cmd_code,
	input  wire logic [7:0]       cmd_value,
	input  wire logic             cmd_term,
	input  wire logic             dev_clear,
	// Settings
	input  wire cqr_pkg::cqr_mode_t sweep_mode_in,
	input  wire logic             sweep_mode_wr,
	input  wire cqr_pkg::cqr_enc_t trace_enc,
	input  wire logic [PTS_W-1:0] acq_points,
	input  wire logic             acq_average,
	input  wire logic [AVG_W-1:0] averaging_count_setting,
	// Acquisition front end
	input  wire logic             sweep_done,
	input  wire logic [7:0]       sample_data,
	output logic                  acq_run,
	output logic                  buf_clear,
	output logic [PTS_W-1:0]      rec_addr,
	// Talker side
	input  wire logic             talk_addressed,
	output logic [7:0]            tx_data,
	output logic                  tx_valid,
	output logic                  tx_end,
	input  wire logic             tx_ready,
	// Status
	output cqr_pkg::cqr_mode_t    sweep_mode,
	output logic                  capture_busy,
	output logic                  rec_valid,
	output logic                  err_push,
	output logic [7:0]            err_code
);
	// =========================================================
	// State
	typedef enum logic [2:0] {
		CQR_IDLE, CQR_CAPT, CQR_HDR, CQR_PTS, CQR_DRAIN
	} cqr_fsm_t;

	typedef struct packed {
		cqr_fsm_t          fsm;
		cqr_pkg::cqr_mode_t mode;
		logic [3:0]        pend;      // Queued queries awaiting terminator
		logic              pend_trace;
		logic              pend_capt;
		logic [7:0]        qval;
		logic              queued;    // Answer waiting in output queue
		logic              resp_any;  // Earlier answer in this message
		logic              acq;
		logic              clr;
		logic              valid_rec;
		logic [AVG_W-1:0]  sweeps;
		logic [PTS_W-1:0]  idx;
		logic [3:0]        hidx;
		logic [2:0]        sub;
		logic [7:0]        tdata;
		logic              tval;
		logic              tend;
		logic              epush;
		logic [7:0]        ecode;
	} cqr_st_t;

	cqr_st_t    s_q, s_d;
	logic [8:0] f_in, f_out;
	logic       f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush;
	logic [15:0] cnt_bcd;

	// Decimal digit of a value at position pos, counted from the units digit
	function automatic logic [7:0] dec_digit(input logic [15:0] v, input int pos);
		logic [15:0] r;
		r = v;
		for (int i = 0; i < pos; i++) begin
			r = r / 16'd10;
		end
		return cqr_pkg::CQR_CH_ZERO + 8'(r % 16'd10);
	endfunction

	// Count of decimal digits needed for a value
	function automatic logic [3:0] dec_len(input logic [15:0] v);
		logic [3:0] n;
		n = 4'h1;
		for (int i = 1; i < cqr_pkg::CQR_CNT_DIGITS; i++) begin
			if (v >= 16'(10 ** i)) begin
				n = 4'(i + 1);
			end
		end
		return n;
	endfunction

	// Bytes per point for the chosen encoding
	function automatic logic [2:0] enc_bytes(input cqr_pkg::cqr_enc_t e);
		case (e)
			cqr_pkg::CQR_ENC_WORD:  return 3'h2;
			cqr_pkg::CQR_ENC_ASCII: return 3'h4;
			default:                return 3'h1;
		endcase
	endfunction

	// Payload byte count: points times bytes per point
	assign cnt_bcd = 16'(acq_points) * 16'(enc_bytes(trace_enc));

	// =========================================================
	// Main control
	always_comb begin
		logic       new_cmd;
		logic [3:0] dl;
		new_cmd = 1'b0;
		dl      = dec_len(cnt_bcd);
		s_d       = s_q;
		s_d.clr   = 1'b0;
		s_d.epush = 1'b0;
		f_in       = '0;
		f_in_valid = 1'b0;
		f_flush    = 1'b0;
		new_cmd    = cmd_valid && (cmd_code != cqr_pkg::CQR_CMD_NONE);
		if (sweep_mode_wr) begin
			s_d.mode      = sweep_mode_in;
			s_d.clr       = 1'b1;
			s_d.valid_rec = 1'b0;
		end
		// Stale answer: discard and log
		if (new_cmd && (s_q.queued || f_out_valid)) begin
			f_flush     = 1'b1;
			s_d.queued  = 1'b0;
			s_d.resp_any = 1'b0;
			s_d.epush   = 1'b1;
			s_d.ecode   = cqr_pkg::CQR_ERR_INTERRUPTED;
			if (s_q.fsm inside {CQR_HDR, CQR_PTS}) begin
				s_d.fsm  = CQR_IDLE;
				s_d.tval = 1'b0;
			end
		end
		// Capture, trace and query commands gather until the terminator; setup and preset act at once
		if (new_cmd) begin
			case (cmd_code)
				cqr_pkg::CQR_CMD_SETUP: begin
					s_d.clr       = 1'b1;
					s_d.valid_rec = 1'b0;
				end
				cqr_pkg::CQR_CMD_PRESET: begin
					s_d.mode = cqr_pkg::CQR_MODE_NORMAL;
					s_d.clr  = 1'b1;
				end
				cqr_pkg::CQR_CMD_CAPTURE: s_d.pend_capt = 1'b1;
				cqr_pkg::CQR_CMD_TRACEQ:  s_d.pend_trace = 1'b1;
				cqr_pkg::CQR_CMD_QUERY: begin
					s_d.qval = cmd_value;
					s_d.pend = s_q.pend + 4'h1;
				end
				default: ;
			endcase
		end
		// Terminator releases the gathered work
		if (cmd_term && s_q.fsm == CQR_IDLE) begin
			if (s_q.pend != '0 && f_in_ready) begin
				f_in       = {1'b0, s_q.qval};
				f_in_valid = 1'b1;
				s_d.queued = 1'b1;
				s_d.pend   = '0;
			end
			if ((s_q.pend_capt || s_q.pend_trace)
					&& s_q.mode != cqr_pkg::CQR_MODE_NORMAL) begin
				s_d.epush      = 1'b1;
				s_d.ecode      = cqr_pkg::CQR_ERR_CONFLICT;
				s_d.pend_capt  = 1'b0;
				s_d.pend_trace = 1'b0;
			end else if (s_q.pend_capt) begin
				s_d.pend_capt = 1'b0;
				s_d.fsm       = CQR_CAPT;
				s_d.acq       = 1'b1;
				s_d.clr       = 1'b1;
				s_d.sweeps    = '0;
				s_d.valid_rec = 1'b0;
			end
		end
		case (s_q.fsm)
			CQR_CAPT: begin
				if (sweep_done) begin
					s_d.sweeps = s_q.sweeps + 1'b1;
					// Averaging needs the set count of sweeps, else one
					if (!acq_average || (s_q.sweeps + 1'b1) >= averaging_count_setting) begin
						s_d.acq       = 1'b0;
						s_d.valid_rec = 1'b1;
						s_d.fsm       = CQR_IDLE;
					end
				end
			end
			CQR_IDLE: begin
				// Trace stream waits for any short answers, then talk address
				if (s_q.pend_trace && s_q.mode == cqr_pkg::CQR_MODE_NORMAL
						&& !f_out_valid && talk_addressed && !cmd_term) begin
					s_d.pend_trace = 1'b0;
					s_d.fsm  = CQR_HDR;
					s_d.hidx = '0;
					s_d.idx  = '0;
					s_d.sub  = '0;
					s_d.tval = 1'b1;
					s_d.tend = 1'b0;
					s_d.tdata = s_q.resp_any ? cqr_pkg::CQR_CH_SEMI
						: cqr_pkg::CQR_CH_HASH;
					s_d.hidx = s_q.resp_any ? 4'hf : 4'h0;
				end
			end
			CQR_HDR: begin
				if (tx_ready && s_q.tval) begin
					s_d.hidx = s_q.hidx + 4'h1;
					if (s_q.hidx == 4'hf) begin
						s_d.tdata = cqr_pkg::CQR_CH_HASH;
					end else if (s_q.hidx == 4'h0) begin
						s_d.tdata = cqr_pkg::CQR_CH_ZERO + 8'(dl);
					end else if (s_q.hidx <= dl) begin
						s_d.tdata = dec_digit(cnt_bcd, int'(dl - s_q.hidx));
					end else begin
						s_d.fsm = CQR_PTS;
					end
					if (s_q.hidx > dl && s_q.hidx != 4'hf) begin
						s_d.tval = 1'b0;
					end
				end
			end
			CQR_PTS: begin
				if (!s_q.tval || tx_ready) begin
					s_d.tval = 1'b1;
					case (trace_enc)
						cqr_pkg::CQR_ENC_WORD:
							s_d.tdata = (s_q.sub == 3'h0) ? sample_data : 8'h00;
						cqr_pkg::CQR_ENC_ASCII:
							s_d.tdata = (s_q.sub == 3'h3) ? cqr_pkg::CQR_CH_COMMA
								: dec_digit({8'h00, sample_data}, 2 - int'(s_q.sub));
						default: s_d.tdata = sample_data;
					endcase
					s_d.sub = s_q.sub + 3'h1;
					if (s_q.sub == enc_bytes(trace_enc) - 3'h1) begin
						s_d.sub = '0;
						s_d.idx = s_q.idx + 1'b1;
						if (s_q.idx == acq_points - 1'b1) begin
							s_d.fsm  = CQR_DRAIN;
							s_d.tend = 1'b1;
						end
					end
				end
			end
			CQR_DRAIN: begin
				if (tx_ready) begin
					s_d.tval     = 1'b0;
					s_d.tend     = 1'b0;
					s_d.resp_any = 1'b0;
					s_d.fsm      = CQR_IDLE;
				end
			end
			default: s_d.fsm = CQR_IDLE;
		endcase
		// Short answers out of the queue
		if (s_q.fsm == CQR_IDLE && f_out_valid && talk_addressed && tx_ready) begin
			s_d.resp_any = 1'b1;
		end
		if (!f_out_valid && !s_q.pend_trace && s_q.fsm == CQR_IDLE) begin
			s_d.queued = 1'b0;
		end
		// Device clear drops all state but the sweep mode and record, and aborts a capture
		if (dev_clear) begin
			f_flush = 1'b1;
			s_d = '0;
			s_d.mode = s_q.mode;
			s_d.valid_rec = (s_q.fsm == CQR_CAPT) ? 1'b0 : s_q.valid_rec;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign f_out_ready = (s_q.fsm == CQR_IDLE) && talk_addressed && tx_ready;

	// Output queue; back-pressure stalls the terminator release
	cqr_fifo #(
		.WIDTH (9),
		.DEPTH (cqr_pkg::CQR_FIFO_DEPTH)
	) u_queue (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.flush     (f_flush),
		.in_data   (f_in),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.out_data  (f_out),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready)
	);

	// =========================================================
	// Outputs from flops
	logic [7:0] qd_q;
	logic       qv_q;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			qd_q <= '0;
			qv_q <= 1'b0;
		end else begin
			qv_q <= f_out_ready && f_out_valid;
			qd_q <= f_out[7:0];
		end
	end

	assign acq_run      = s_q.acq;
	assign buf_clear    = s_q.clr;
	assign rec_addr     = s_q.idx;
	assign tx_data      = qv_q ? qd_q : s_q.tdata;
	assign tx_valid     = qv_q || s_q.tval;
	assign tx_end       = s_q.tend;
	assign sweep_mode   = s_q.mode;
	assign capture_busy = (s_q.fsm == CQR_CAPT);
	assign rec_valid    = s_q.valid_rec;
	assign err_push     = s_q.epush;
	assign err_code     = s_q.ecode;

	// =========================================================
	// Checks
	a_conflict_err: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmd_term && s_q.fsm == CQR_IDLE && s_q.pend_capt && !dev_clear
		&& s_q.mode != cqr_pkg::CQR_MODE_NORMAL |=> err_push && !capture_busy)
		else $error("capture ran outside normal sweep");
	a_capture_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
		capture_busy && sweep_done && !acq_average && !dev_clear |=> !acq_run && rec_valid)
		else $error("capture did not stop");
	a_preset_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmd_valid && cmd_code == cqr_pkg::CQR_CMD_PRESET && !sweep_mode_wr && !dev_clear
		|=> sweep_mode == cqr_pkg::CQR_MODE_NORMAL) else $error("preset missed mode");
	a_setup_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmd_valid && cmd_code == cqr_pkg::CQR_CMD_SETUP && !dev_clear |=> buf_clear)
		else $error("setup did not clear buffers");
	a_clear_abort: assert property (@(posedge core_clk) disable iff (sys_rst)
		dev_clear |=> !capture_busy && !acq_run) else $error("clear left capture running");
	a_talk_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(s_q.fsm == CQR_HDR) |-> $past(talk_addressed)) else $error("sent untalked");
	a_stale_err: assert property (@(posedge core_clk) disable iff (sys_rst)
		cmd_valid && cmd_code != cqr_pkg::CQR_CMD_NONE && f_out_valid && !dev_clear
		|=> err_push) else $error("stale answer not reported");
	a_hdr_hash: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(s_q.fsm == CQR_HDR) && !$past(s_q.resp_any) |-> tx_data == cqr_pkg::CQR_CH_HASH)
		else $error("block header missing hash");
	c_capture: cover property (@(posedge core_clk) capture_busy ##[1:20] rec_valid);
	c_stream:  cover property (@(posedge core_clk) s_q.fsm == CQR_PTS ##[1:50] tx_end);
	c_stale:   cover property (@(posedge core_clk) err_push && err_code == cqr_pkg::CQR_ERR_INTERRUPTED);
endmodule

// File: test/cqr_ctrl_model.sv
`timescale 1ns/1ps

// =========================================================
// Controller reader: addresses the engine to talk, takes bytes
module cqr_ctrl_model (
	// Clock
	input  wire logic       core_clk,
	// Bench control
	input  wire logic       listen_en,
	input  wire logic       stall,
	// Talker side of the engine
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       tx_end,
	output logic            talk_addressed,
	output logic            tx_ready
);
	logic [7:0] rx_q[$];
	int         end_cnt;
	int         end_pos;
	logic       phase_q;

	// Idle until the bench asks for a read
	initial begin
		talk_addressed = 1'b0;
		tx_ready = 1'b0;
		phase_q = 1'b0;
		end_cnt = 0;
		end_pos = -1;
	end

	// Drive off the sampling edge; a stall drops ready every other cycle
	always @(negedge core_clk) begin
		phase_q <= ~phase_q;
		talk_addressed <= listen_en;
		tx_ready <= listen_en && !(stall && phase_q);
	end

	// One read takes every byte offered until the bench releases it
	always @(posedge core_clk) begin
		if (tx_valid === 1'b1 && tx_ready) begin
			rx_q.push_back(tx_data);
			if (tx_end === 1'b1) begin
				end_cnt++;
				end_pos = rx_q.size() - 1;
			end
		end
	end
endmodule

// File: test/test_capture_and_query_response_engine.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module test_capture_and_query_response_engine;
	logic               core_clk, sys_rst, cmd_valid, cmd_term, dev_clear, sweep_mode_wr;
	logic               acq_average, sweep_done, acq_run, buf_clear, talk_addressed;
	logic               tx_valid, tx_end, tx_ready, capture_busy, rec_valid, err_push;
	logic               listen_en, stall;
	logic [7:0]         cmd_value, averaging_count_setting, sample_data, tx_data, err_code;
	logic [7:0]         last_err;
	logic [9:0]         acq_points, rec_addr;
	cqr_pkg::cqr_cmd_t  cmd_code;
	cqr_pkg::cqr_mode_t sweep_mode_in, sweep_mode;
	cqr_pkg::cqr_enc_t  trace_enc;
	int                 failures, n_checks, n_clear, n_err;

	cqr_engine cqr_engine_i (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_value(cmd_value), .cmd_term(cmd_term), .dev_clear(dev_clear),
		.sweep_mode_in(sweep_mode_in), .sweep_mode_wr(sweep_mode_wr), .trace_enc(trace_enc),
		.acq_points(acq_points), .acq_average(acq_average),
		.averaging_count_setting(averaging_count_setting), .sweep_done(sweep_done),
		.sample_data(sample_data), .acq_run(acq_run), .buf_clear(buf_clear),
		.rec_addr(rec_addr), .talk_addressed(talk_addressed), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_end(tx_end), .tx_ready(tx_ready), .sweep_mode(sweep_mode),
		.capture_busy(capture_busy), .rec_valid(rec_valid), .err_push(err_push),
		.err_code(err_code));
	cqr_ctrl_model cqr_ctrl_model_i (.core_clk(core_clk), .listen_en(listen_en),
		.stall(stall), .tx_data(tx_data), .tx_valid(tx_valid), .tx_end(tx_end),
		.talk_addressed(talk_addressed), .tx_ready(tx_ready));

	// Record memory stand-in: a value that differs at each of the first 256 points
	assign sample_data = rec_addr[7:0] ^ 8'h5a;

	// Clock at 25 ns
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Count one-cycle pulses where they are settled
	always @(negedge core_clk) begin
		if (buf_clear === 1'b1) n_clear++;
		if (err_push === 1'b1) begin
			n_err++;
			last_err = err_code;
		end
	end

	task tick(int n);
		repeat (n) @(negedge core_clk);
	endtask

	task cmd(cqr_pkg::cqr_cmd_t c, logic [7:0] v);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_value = v;
		tick(1);
		cmd_valid = 1'b0;
	endtask

	// Terminator is sent apart from the command so execution waits on it
	task term();
		cmd_term = 1'b1;
		tick(1);
		cmd_term = 1'b0;
		tick(2);
	endtask

	task done_pulse();
		sweep_done = 1'b1;
		tick(1);
		sweep_done = 1'b0;
		tick(2);
	endtask

	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task t_capture();
		acq_average = 1'b1;
		averaging_count_setting = 8'h03;
		cmd(cqr_pkg::CQR_CMD_CAPTURE, 8'h00);
		tick(3);
		`CHK("acq_run before term", 1'b0, acq_run)
		term();
		`CHK("acq_run started", 1'b1, acq_run)
		done_pulse();
		done_pulse();
		`CHK("acq_run short of count", 1'b1, acq_run)
		done_pulse();
		`CHK("acq_run after count", 1'b0, acq_run)
		`CHK("rec_valid frozen", 1'b1, rec_valid)
		acq_average = 1'b0;
		$display("test capture done");
	endtask

	task t_conflict();
		int c0;
		int e0;
		for (int m = 1; m < 4; m++) begin
			c0 = n_clear;
			e0 = n_err;
			sweep_mode_in = cqr_pkg::cqr_mode_t'(m);
			sweep_mode_wr = 1'b1;
			tick(1);
			sweep_mode_wr = 1'b0;
			tick(3);
			`CHK("buf_clear count", c0 + 1, n_clear)
			cmd(cqr_pkg::CQR_CMD_CAPTURE, 8'h00);
			term();
			`CHK("acq_run in mode", 1'b0, acq_run)
			cmd(cqr_pkg::CQR_CMD_TRACEQ, 8'h00);
			term();
			`CHK("conflict count", e0 + 2, n_err)
			`CHK("conflict code", cqr_pkg::CQR_ERR_CONFLICT, last_err)
			cmd(cqr_pkg::CQR_CMD_PRESET, 8'h00);
			term();
			`CHK("mode after preset", cqr_pkg::CQR_MODE_NORMAL, sweep_mode)
		end
		$display("test conflict done");
	endtask

	task t_trace(cqr_pkg::cqr_enc_t e, int pts);
		logic [7:0] exp_q[$];
		int n, nd, s, i;
		trace_enc = e;
		acq_points = 10'(pts);
		cmd(cqr_pkg::CQR_CMD_CAPTURE, 8'h00);
		term();
		done_pulse();
		n = pts * ((e == cqr_pkg::CQR_ENC_BYTE) ? 1 : (e == cqr_pkg::CQR_ENC_WORD) ? 2 : 4);
		nd = (n >= 100) ? 3 : (n >= 10) ? 2 : 1;
		exp_q = {cqr_pkg::CQR_CH_HASH, 8'(48 + nd)};
		for (i = nd - 1; i >= 0; i--) exp_q.push_back(8'(48 + (n / (10 ** i)) % 10));
		for (i = 0; i < pts; i++) begin
			s = (i ^ 'h5a) & 'hff;
			if (e == cqr_pkg::CQR_ENC_BYTE) exp_q.push_back(8'(s));
			if (e == cqr_pkg::CQR_ENC_WORD) exp_q = {exp_q, 8'(s), 8'h00};
			if (e == cqr_pkg::CQR_ENC_ASCII) exp_q = {exp_q, 8'(48 + s / 100),
				8'(48 + (s / 10) % 10), 8'(48 + s % 10), cqr_pkg::CQR_CH_COMMA};
		end
		cqr_ctrl_model_i.rx_q.delete();
		cqr_ctrl_model_i.end_cnt = 0;
		cmd(cqr_pkg::CQR_CMD_TRACEQ, 8'h00);
		term();
		tick(10);
		`CHK("tx_valid unaddressed", 1'b0, tx_valid)
		stall = (e == cqr_pkg::CQR_ENC_WORD);
		listen_en = 1'b1;
		for (i = 0; i < 600 && cqr_ctrl_model_i.end_cnt == 0; i++) tick(1);
		listen_en = 1'b0;
		stall = 1'b0;
		if (i == 600) begin
			failures++;
			tally_and_finish();
		end
		tick(4);
		`CHK("block length", exp_q.size(), cqr_ctrl_model_i.rx_q.size())
		`CHK("end position", exp_q.size() - 1, cqr_ctrl_model_i.end_pos)
		for (i = 0; i < exp_q.size() && i < cqr_ctrl_model_i.rx_q.size(); i++)
			`CHK("block byte", exp_q[i], cqr_ctrl_model_i.rx_q[i])
		$display("test trace encoding %0d done", e);
	endtask

	task t_query();
		int e0;
		cqr_ctrl_model_i.rx_q.delete();
		cmd(cqr_pkg::CQR_CMD_QUERY, 8'h41);
		term();
		listen_en = 1'b1;
		tick(12);
		listen_en = 1'b0;
		`CHK("answer count", 1, cqr_ctrl_model_i.rx_q.size())
		`CHK("answer byte", 8'h41, cqr_ctrl_model_i.rx_q[0])
		e0 = n_err;
		cmd(cqr_pkg::CQR_CMD_QUERY, 8'h42);
		term();
		cmd(cqr_pkg::CQR_CMD_SETUP, 8'h00);
		term();
		`CHK("flush error code", cqr_pkg::CQR_ERR_INTERRUPTED, last_err)
		`CHK("flush error count", e0 + 1, n_err)
		listen_en = 1'b1;
		tick(12);
		listen_en = 1'b0;
		`CHK("nothing after flush", 1, cqr_ctrl_model_i.rx_q.size())
		$display("test query done");
	endtask

	task t_clear();
		cmd(cqr_pkg::CQR_CMD_CAPTURE, 8'h00);
		term();
		`CHK("acq_run before clear", 1'b1, acq_run)
		dev_clear = 1'b1;
		tick(1);
		dev_clear = 1'b0;
		tick(3);
		`CHK("acq_run aborted", 1'b0, acq_run)
		`CHK("capture_busy aborted", 1'b0, capture_busy)
		cmd(cqr_pkg::CQR_CMD_CAPTURE, 8'h00);
		dev_clear = 1'b1;
		tick(1);
		dev_clear = 1'b0;
		term();
		`CHK("dropped command", 1'b0, acq_run)
		$display("test clear done");
	endtask

	// Reset for 16 cycles, then the scenarios
	initial begin
		{sys_rst, cmd_valid, cmd_term, dev_clear, sweep_mode_wr} = 5'h10;
		{acq_average, sweep_done, listen_en, stall} = 4'h0;
		cmd_code = cqr_pkg::CQR_CMD_NONE;
		cmd_value = 8'h00;
		sweep_mode_in = cqr_pkg::CQR_MODE_NORMAL;
		trace_enc = cqr_pkg::CQR_ENC_BYTE;
		acq_points = 10'h004;
		averaging_count_setting = 8'h01;
		{failures, n_checks, n_clear, n_err} = 0;
		tick(16);
		sys_rst = 1'b0;
		tick(1);
		`CHK("mode at reset", cqr_pkg::CQR_MODE_NORMAL, sweep_mode)
		`CHK("tx_valid at reset", 1'b0, tx_valid)
		t_capture();
		t_conflict();
		t_trace(cqr_pkg::CQR_ENC_BYTE, 3);
		t_trace(cqr_pkg::CQR_ENC_WORD, 5);
		t_trace(cqr_pkg::CQR_ENC_ASCII, 4);
		t_query();
		t_clear();
		tally_and_finish();
	end
endmodule
